/* File: inc/sercfg_pkg.sv */
// Purpose: constants for the serializer general configuration register bank
// Assumes: byte-wide registers, byte offsets 0x00 to 0x03 on the serial target port
// Notes: strap values are caught when the power-down pin rises
// Operation
// - strap-set fields reset from sampled strap pins
// - identifier field writable only while override set
// - identifier field always shows identifier in use
// - reload bit starts default reload, self-clears
// - reset bit one clears logic and registers
// - reset bit zero clears logic, keeps registers
// - bit 6 selects continuous clock lane
// - bits 5:4 select lane count, reset 3
// - bit 1 enables check-code generator, resets on
// - bit 0 shows strapped level, stays writable
// - mode field writable only while override set
// - settled bit rises once mode latched
// - mode strap captured on power-down pin rise
// - mode codes: sync, ext, internal, parallel
package sercfg_pkg;
  // ---------------------------------------------------------------
  // register offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] OFS_IDENT = 8'h00;
  localparam logic [7:0] OFS_RESET = 8'h01;
  localparam logic [7:0] OFS_GENCFG = 8'h02;
  localparam logic [7:0] OFS_MODE = 8'h03;
  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int IDENT_OVR_BIT = 0;
  localparam int IDENT_LSB = 1;
  localparam int RST_DIG0_BIT = 0;
  localparam int RST_DIG1_BIT = 1;
  localparam int RST_RELOAD_BIT = 2;
  localparam int SC_BITS = 3;
  localparam int CFG_LEVEL_BIT = 0;
  localparam int CFG_CRC_BIT = 1;
  localparam int CFG_LANE_LSB = 4;
  localparam int CFG_CONT_BIT = 6;
  localparam int MODE_LSB = 0;
  localparam int MODE_DONE_BIT = 3;
  localparam int MODE_OVR_BIT = 4;
  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [1:0] LANE_RST = 2'h3;
  localparam logic CRC_RST = 1'b1;
  localparam logic CONT_RST = 1'b0;
  localparam logic [7:0] RSVD_RD = 8'h00;
  // ---------------------------------------------------------------
  // operating modes
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    MODE_SYNC = 3'b000,
    MODE_RSVD = 3'b001,
    MODE_NSYNC_EXT = 3'b010,
    MODE_NSYNC_OSC = 3'b011,
    MODE_PAR_EXT = 3'b101
  } op_mode_e;
  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int MCLK_PERIOD_NS = 8;
  localparam int SC_HOLD_NS = 64;
  localparam int SC_HOLD_CYCLES = (SC_HOLD_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;
  localparam int SETTLE_NS = 32;
  localparam int SETTLE_CYCLES = (SETTLE_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;
  localparam logic [3:0] BYTE_BITS = 4'h8;
endpackage : sercfg_pkg

/* File: design/pin_sync.sv */
// Purpose: two-flop synchroniser for pins entering the mclk domain
// Assumes: inputs are static or slow against mclk
// Notes: only the second flop is visible outside
`timescale 1ns/100ps
module pin_sync #(
  parameter int WIDTH = 1
) (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic ce,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta;

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      meta <= '0;
      q <= '0;
    end else if (ce) begin
      meta <= d;
      q <= meta;
    end
  end
endmodule : pin_sync

/* File: design/selfclr_pulse.sv */
// Purpose: hold timer behind one self-clearing control bit
// Assumes: start is a one-cycle pulse in the mclk domain
// Notes: a new start restarts the hold
`timescale 1ns/100ps
module selfclr_pulse #(
  parameter int HOLD = 8
) (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic ce,
  input wire logic start,
  output logic busy
);
  localparam int CW = $clog2(HOLD + 1);
  localparam logic [CW-1:0] HOLD_C = CW'(HOLD);
  logic [CW-1:0] cnt;

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      cnt <= '0;
    end else if (ce) begin
      if (start) begin
        cnt <= HOLD_C;
      end else if (cnt != '0) begin
        cnt <= cnt - 1'b1;
      end
    end
  end

  assign busy = (cnt != '0);
endmodule : selfclr_pulse

/* File: design/serializer_general_config_regs.sv */
// Purpose: general configuration registers behind a serial two-wire target port
// Assumes: scl and sda sampled by mclk, scl much slower than mclk
// Notes: reserved fields read zero; data outputs registered
`timescale 1ns/100ps
module serializer_general_config_regs
  import sercfg_pkg::*;
#(
  parameter int HOLD_CYCLES = SC_HOLD_CYCLES,
  parameter int SETTLE = SETTLE_CYCLES
) (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic ce,
  input wire logic scl_pin,
  input wire logic sda_pin_in,
  output logic sda_pin_out,
  output logic sda_pin_oe,
  input wire logic power_down_pin,
  input wire logic [6:0] ident_strap_pin,
  input wire logic [2:0] mode_strap_pin,
  input wire logic level_strap_pin,
  output logic [6:0] bus_target_ident,
  output logic clock_lane_continuous,
  output logic [1:0] data_lane_sel,
  output logic crc_gen_enable,
  output logic i2c_level_1v8,
  output logic [2:0] op_mode,
  output logic op_mode_settled,
  output logic rom_reload_trigger,
  output logic core_soft_reset
);
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0000,
    ST_ADDR = 4'b0001,
    ST_ADDR_ACK = 4'b0010,
    ST_PTR = 4'b0011,
    ST_PTR_ACK = 4'b0100,
    ST_WDATA = 4'b0101,
    ST_WDATA_ACK = 4'b0110,
    ST_RDATA = 4'b0111,
    ST_RDATA_ACK = 4'b1000
  } tgt_state_e;

  localparam int PINS = 14;
  localparam int SC_BOUND = HOLD_CYCLES + 1;
  localparam int SW = $clog2(SETTLE + 1);
  localparam logic [SW-1:0] SETTLE_C = SW'(SETTLE);

  // ---------------------------------------------------------------
  // pin synchronisers and edges
  // ---------------------------------------------------------------
  logic [PINS-1:0] pins_s;
  logic scl_s, sda_s, pwr_s, level_s;
  logic [6:0] ident_s;
  logic [2:0] mode_s;
  logic scl_q, sda_q, pwr_q;

  pin_sync #(.WIDTH(PINS)) u_sync (
    .mclk(mclk),
    .arst_n(arst_n),
    .ce(ce),
    .d({level_strap_pin, mode_strap_pin, ident_strap_pin, power_down_pin, ~sda_pin_in,
        ~scl_pin}),
    .q(pins_s)
  );

  // bus pins pass inverted: cleared synchroniser means idle bus, no false edge
  assign scl_s = ~pins_s[0];
  assign sda_s = ~pins_s[1];
  assign pwr_s = pins_s[2];
  assign ident_s = pins_s[9:3];
  assign mode_s = pins_s[12:10];
  assign level_s = pins_s[13];

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      pwr_q <= 1'b0;
    end else if (ce) begin
      scl_q <= scl_s;
      sda_q <= sda_s;
      pwr_q <= pwr_s;
    end
  end

  logic scl_rise, scl_fall, bus_start, bus_stop, pwr_rise;
  assign scl_rise = scl_s & ~scl_q;
  assign scl_fall = ~scl_s & scl_q;
  assign bus_start = scl_s & scl_q & sda_q & ~sda_s;
  assign bus_stop = scl_s & scl_q & ~sda_q & sda_s;
  assign pwr_rise = pwr_s & ~pwr_q;

  // ---------------------------------------------------------------
  // strap capture and mode settling
  // ---------------------------------------------------------------
  logic [6:0] strap_ident;
  logic [2:0] strap_mode;
  logic [SW-1:0] settle_cnt;

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      strap_ident <= 7'h00;
      strap_mode <= 3'h0;
    end else if (ce && pwr_rise) begin
      strap_ident <= ident_s;
      strap_mode <= mode_s;
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      settle_cnt <= '0;
      op_mode_settled <= 1'b0;
    end else if (ce) begin
      if (!pwr_s || pwr_rise) begin
        settle_cnt <= SETTLE_C;
        op_mode_settled <= 1'b0;
      end else if (settle_cnt != '0) begin
        settle_cnt <= settle_cnt - 1'b1;
      end else begin
        op_mode_settled <= 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // register image
  // ---------------------------------------------------------------
  logic ident_override, op_mode_override;
  logic [SC_BITS-1:0] sc_start, sc_busy;

  function automatic logic [7:0] reg_image(input logic [7:0] a);
    logic [7:0] v;
    v = RSVD_RD;
    unique case (a)
      OFS_IDENT: begin
        v[IDENT_LSB +: 7] = bus_target_ident;
        v[IDENT_OVR_BIT] = ident_override;
      end
      OFS_RESET: v[SC_BITS-1:0] = sc_busy;
      OFS_GENCFG: begin
        v[CFG_CONT_BIT] = clock_lane_continuous;
        v[CFG_LANE_LSB +: 2] = data_lane_sel;
        v[CFG_CRC_BIT] = crc_gen_enable;
        v[CFG_LEVEL_BIT] = i2c_level_1v8;
      end
      OFS_MODE: begin
        v[MODE_OVR_BIT] = op_mode_override;
        v[MODE_DONE_BIT] = op_mode_settled;
        v[MODE_LSB +: 3] = op_mode;
      end
      default: v = RSVD_RD;
    endcase
    return v;
  endfunction : reg_image

  // ---------------------------------------------------------------
  // serial target engine
  // ---------------------------------------------------------------
  tgt_state_e state;
  logic [7:0] shreg, ptr, wr_addr, wr_data, rd_word;
  logic [3:0] bitcnt;
  logic is_read, wr_stb;

  assign sda_pin_out = 1'b0;
  assign rd_word = reg_image(ptr);

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      state <= ST_IDLE;
      shreg <= 8'h00;
      ptr <= 8'h00;
      bitcnt <= 4'h0;
      is_read <= 1'b0;
      sda_pin_oe <= 1'b0;
      wr_stb <= 1'b0;
      wr_addr <= 8'h00;
      wr_data <= 8'h00;
    end else if (ce) begin
      wr_stb <= 1'b0;
      if (!pwr_s || bus_stop) begin
        state <= ST_IDLE;
        sda_pin_oe <= 1'b0;
      end else if (bus_start) begin
        state <= ST_ADDR;
        bitcnt <= 4'h0;
        sda_pin_oe <= 1'b0;
      end else begin
        unique case (state)
          ST_IDLE: begin
            sda_pin_oe <= 1'b0;
          end
          ST_ADDR, ST_PTR, ST_WDATA: begin
            if (scl_rise) begin
              shreg <= {shreg[6:0], sda_s};
              bitcnt <= bitcnt + 4'h1;
            end
            if (scl_fall && bitcnt == BYTE_BITS) begin
              bitcnt <= 4'h0;
              if (state == ST_ADDR) begin
                if (shreg[7:1] == bus_target_ident) begin
                  sda_pin_oe <= 1'b1;
                  is_read <= shreg[0];
                  state <= ST_ADDR_ACK;
                end else begin
                  state <= ST_IDLE;
                end
              end else if (state == ST_PTR) begin
                ptr <= shreg;
                sda_pin_oe <= 1'b1;
                state <= ST_PTR_ACK;
              end else begin
                wr_stb <= 1'b1;
                wr_addr <= ptr;
                wr_data <= shreg;
                ptr <= ptr + 8'h01;
                sda_pin_oe <= 1'b1;
                state <= ST_WDATA_ACK;
              end
            end
          end
          ST_PTR_ACK, ST_WDATA_ACK: begin
            if (scl_fall) begin
              sda_pin_oe <= 1'b0;
              state <= ST_WDATA;
            end
          end
          ST_ADDR_ACK, ST_RDATA_ACK: begin
            if (state == ST_RDATA_ACK && scl_rise && sda_s) begin
              state <= ST_IDLE;
            end else if (scl_fall && (state == ST_RDATA_ACK || is_read)) begin
              // a read load would release latched fields; this bank has none
              shreg <= rd_word;
              sda_pin_oe <= ~rd_word[7];
              ptr <= ptr + 8'h01;
              bitcnt <= 4'h0;
              state <= ST_RDATA;
            end else if (scl_fall) begin
              sda_pin_oe <= 1'b0;
              state <= ST_PTR;
            end
          end
          ST_RDATA: begin
            if (scl_rise) begin
              bitcnt <= bitcnt + 4'h1;
            end
            if (scl_fall) begin
              if (bitcnt == BYTE_BITS) begin
                sda_pin_oe <= 1'b0;
                state <= ST_RDATA_ACK;
              end else begin
                shreg <= {shreg[6:0], 1'b0};
                sda_pin_oe <= ~shreg[6];
              end
            end
          end
        endcase
      end
    end
  end

  // ---------------------------------------------------------------
  // self-clearing reset and reload controls
  // ---------------------------------------------------------------
  logic regs_clear;

  for (genvar g = 0; g < SC_BITS; g++) begin : g_sc
    assign sc_start[g] = wr_stb && wr_addr == OFS_RESET && wr_data[g];
    selfclr_pulse #(.HOLD(HOLD_CYCLES)) u_sc (
      .mclk(mclk),
      .arst_n(arst_n),
      .ce(ce),
      .start(sc_start[g]),
      .busy(sc_busy[g])
    );
  end

  assign regs_clear = sc_start[RST_DIG1_BIT] | sc_start[RST_RELOAD_BIT];

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      rom_reload_trigger <= 1'b0;
      core_soft_reset <= 1'b0;
    end else if (ce) begin
      rom_reload_trigger <= sc_start[RST_RELOAD_BIT];
      core_soft_reset <= sc_busy[RST_DIG0_BIT] | sc_busy[RST_DIG1_BIT];
    end
  end

  // ---------------------------------------------------------------
  // configuration registers
  // ---------------------------------------------------------------
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      ident_override <= 1'b0;
      bus_target_ident <= 7'h00;
      clock_lane_continuous <= CONT_RST;
      data_lane_sel <= LANE_RST;
      crc_gen_enable <= CRC_RST;
      i2c_level_1v8 <= 1'b0;
      op_mode_override <= 1'b0;
      op_mode <= 3'h0;
    end else if (ce) begin
      if (regs_clear) begin
        ident_override <= 1'b0;
        bus_target_ident <= strap_ident;
        clock_lane_continuous <= CONT_RST;
        data_lane_sel <= LANE_RST;
        crc_gen_enable <= CRC_RST;
        i2c_level_1v8 <= level_s;
        op_mode_override <= 1'b0;
        op_mode <= strap_mode;
      end else begin
        if (!ident_override) begin
          bus_target_ident <= strap_ident;
        end
        if (!op_mode_override) begin
          op_mode <= strap_mode;
        end
        if (pwr_rise) begin
          i2c_level_1v8 <= level_s;
        end
        if (wr_stb) begin
          unique case (wr_addr)
            OFS_IDENT: begin
              ident_override <= wr_data[IDENT_OVR_BIT];
              if (wr_data[IDENT_OVR_BIT]) begin
                bus_target_ident <= wr_data[IDENT_LSB +: 7];
              end
            end
            OFS_GENCFG: begin
              clock_lane_continuous <= wr_data[CFG_CONT_BIT];
              data_lane_sel <= wr_data[CFG_LANE_LSB +: 2];
              crc_gen_enable <= wr_data[CFG_CRC_BIT];
              i2c_level_1v8 <= wr_data[CFG_LEVEL_BIT];
            end
            OFS_MODE: begin
              op_mode_override <= wr_data[MODE_OVR_BIT];
              if (wr_data[MODE_OVR_BIT]) begin
                op_mode <= wr_data[MODE_LSB +: 3];
              end
            end
            default: begin
            end
          endcase
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  a_ident_follows_strap: assert property (@(posedge mclk) disable iff (!arst_n)
    ce && !ident_override && !wr_stb && !regs_clear |=> bus_target_ident == $past(strap_ident))
    else $error("identifier not tracking strap");

  a_ident_override_wr: assert property (@(posedge mclk) disable iff (!arst_n)
    ce && wr_stb && wr_addr == OFS_IDENT && wr_data[IDENT_OVR_BIT] && !regs_clear
    |=> ident_override && bus_target_ident == $past(wr_data[7:1]))
    else $error("override identifier not taken");

  a_reload_pulse: assert property (@(posedge mclk) disable iff (!arst_n)
    ce && sc_start[RST_RELOAD_BIT] |=> rom_reload_trigger ##1 !rom_reload_trigger)
    else $error("reload trigger not one pulse");

  a_sc_bits_drop: assert property (@(posedge mclk) disable iff (!arst_n)
    ce && |sc_start |=> (|sc_busy) ##[1:SC_BOUND] !(|sc_busy))
    else $error("self-clearing bit stuck");

  a_full_reset_defaults: assert property (@(posedge mclk) disable iff (!arst_n)
    ce && sc_start[RST_DIG1_BIT] |=> data_lane_sel == LANE_RST && crc_gen_enable
    && !clock_lane_continuous && !ident_override && !op_mode_override ##1 core_soft_reset)
    else $error("full soft reset incomplete");

  a_logic_reset_keeps: assert property (@(posedge mclk) disable iff (!arst_n)
    ce && sc_start[RST_DIG0_BIT] && !regs_clear
    |=> $stable(data_lane_sel) && $stable(crc_gen_enable) ##1 core_soft_reset)
    else $error("logic reset disturbed registers");

  a_gencfg_write: assert property (@(posedge mclk) disable iff (!arst_n)
    ce && wr_stb && wr_addr == OFS_GENCFG && !regs_clear
    |=> clock_lane_continuous == $past(wr_data[CFG_CONT_BIT])
    && data_lane_sel == $past(wr_data[5:4]) && crc_gen_enable == $past(wr_data[CFG_CRC_BIT]))
    else $error("configuration write lost");

  a_level_strap: assert property (@(posedge mclk) disable iff (!arst_n)
    ce && pwr_rise && !regs_clear && !wr_stb |=> i2c_level_1v8 == $past(level_s))
    else $error("level not taken from strap");

  a_mode_locked: assert property (@(posedge mclk) disable iff (!arst_n)
    ce && !op_mode_override && !wr_stb && !regs_clear |=> op_mode == $past(strap_mode))
    else $error("mode not tracking strap");

  a_mode_capture: assert property (@(posedge mclk) disable iff (!arst_n)
    ce && pwr_rise |=> strap_mode == $past(mode_s) && !op_mode_settled)
    else $error("mode strap not captured");

  a_mode_settles: assert property (@(posedge mclk) disable iff (!arst_n)
    ce && pwr_rise ##1 (ce && pwr_s) [*8] |-> op_mode_settled)
    else $error("settled flag late");
endmodule : serializer_general_config_regs

/* File: test/i2c_host_model.sv */
// Purpose: two-wire host model for the register target port
// Assumes: sda is the resolved wire with a pull-up
// Notes: scl period 10 mclk, scl idles high between frames
`timescale 1ns/100ps
module i2c_host_model (
  input wire logic mclk,
  input wire logic sda,
  output logic scl,
  output logic sda_pull
);
  initial begin
    scl = 1'b1;
    sda_pull = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(negedge mclk);
  endtask : tick
  task automatic bit_io(input logic b, output logic s);
    tick(1);
    sda_pull = ~b;
    tick(4);
    scl = 1'b1;
    tick(4);
    s = sda;
    tick(1);
    scl = 1'b0;
  endtask : bit_io
  // start or repeated start
  task automatic start;
    tick(1);
    sda_pull = 1'b0;
    tick(4);
    scl = 1'b1;
    tick(4);
    sda_pull = 1'b1;
    tick(4);
    scl = 1'b0;
  endtask : start
  task automatic stop;
    tick(1);
    sda_pull = 1'b1;
    tick(4);
    scl = 1'b1;
    tick(4);
    sda_pull = 1'b0;
    tick(4);
  endtask : stop
  task automatic byte_io(input logic [7:0] tx, input logic ackb, output logic [7:0] rx,
                         output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(tx[i], rx[i]);
    end
    bit_io(ackb, s);
    ack = ~s;
  endtask : byte_io
  // accesses here stand for the remote back channel
  task automatic reg_write(input logic [6:0] a, input logic [7:0] ofs, input logic [7:0] d,
                           output logic ok);
    logic [7:0] rx;
    logic k0, k1, k2;
    start();
    byte_io({a, 1'b0}, 1'b1, rx, k0);
    byte_io(ofs, 1'b1, rx, k1);
    byte_io(d, 1'b1, rx, k2);
    stop();
    ok = k0 & k1 & k2;
  endtask : reg_write
  task automatic reg_read(input logic [6:0] a, input logic [7:0] ofs, output logic [7:0] d,
                          output logic ok);
    logic [7:0] rx;
    logic k0, k1, k2, nk;
    start();
    byte_io({a, 1'b0}, 1'b1, rx, k0);
    byte_io(ofs, 1'b1, rx, k1);
    start();
    byte_io({a, 1'b1}, 1'b1, rx, k2);
    byte_io(8'hff, 1'b1, d, nk);
    stop();
    ok = k0 & k1 & k2;
  endtask : reg_read
endmodule : i2c_host_model

/* File: test/serializer_general_config_regs_tb_top.sv */
// Purpose: self-checking bench for the general configuration registers
// Assumes: host model drives scl and pulls sda
// Notes: straps and data drawn from a fixed seed
`timescale 1ns/100ps
module serializer_general_config_regs_tb_top;
  import sercfg_pkg::*;
  logic mclk, arst_n, ce, power_down_pin, scl, sda_pull, sda, sda_pin_out, sda_pin_oe;
  logic [6:0] ident_strap, nid, cur_id, bus_target_ident;
  logic [2:0] mode_strap, op_mode;
  logic level_strap, clock_lane_continuous, crc_gen_enable, i2c_level_1v8;
  logic op_mode_settled, rom_reload_trigger, core_soft_reset;
  logic [1:0] data_lane_sel;
  logic [7:0] d, got;
  int err_total, checked, cycles, ms, n_core, n_reload, b_core, b_reload;
  logic [2:0] codes [4] = '{3'h0, 3'h2, 3'h3, 3'h5};
  logic [1:0] lanes [3] = '{2'h0, 2'h1, 2'h3};
  initial mclk = 1'b0;
  always #4 mclk = ~mclk;
  assign sda = ~(sda_pull | (sda_pin_oe & ~sda_pin_out));
  always @(negedge mclk) begin
    cycles++;
    n_core += int'(core_soft_reset === 1'b1);
    n_reload += int'(rom_reload_trigger === 1'b1);
    if (cycles == 60000) begin
      err_total++;
      tally_and_finish();
    end
  end
  i2c_host_model i_i2c_host_model (.mclk(mclk), .sda(sda), .scl(scl), .sda_pull(sda_pull));
  serializer_general_config_regs #(.HOLD_CYCLES(8), .SETTLE(4)) i_serializer_general_config_regs (
    .mclk(mclk), .arst_n(arst_n), .ce(ce), .scl_pin(scl), .sda_pin_in(sda),
    .sda_pin_out(sda_pin_out), .sda_pin_oe(sda_pin_oe), .power_down_pin(power_down_pin),
    .ident_strap_pin(ident_strap), .mode_strap_pin(mode_strap), .level_strap_pin(level_strap),
    .bus_target_ident(bus_target_ident), .clock_lane_continuous(clock_lane_continuous),
    .data_lane_sel(data_lane_sel), .crc_gen_enable(crc_gen_enable),
    .i2c_level_1v8(i2c_level_1v8), .op_mode(op_mode), .op_mode_settled(op_mode_settled),
    .rom_reload_trigger(rom_reload_trigger), .core_soft_reset(core_soft_reset));
  // ---------------------------------------------------------------
  // expectations and bus helpers
  // ---------------------------------------------------------------
  function automatic logic [7:0] cfg_dflt(input logic lvl);
    return {1'b0, CONT_RST, LANE_RST, 2'b00, CRC_RST, lvl};
  endfunction : cfg_dflt
  function automatic logic [7:0] mode_rd(input logic ovr, input logic [2:0] m);
    return {3'b000, ovr, 1'b1, m};
  endfunction : mode_rd
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    checked++;
    if (g !== e) begin
      err_total++;
      $display("mismatch %0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  task automatic idle(input int n);
    repeat (n) @(negedge mclk);
  endtask : idle
  task automatic wr(input logic [7:0] ofs, input logic [7:0] v);
    logic ok;
    i_i2c_host_model.reg_write(cur_id, ofs, v, ok);
    chk({7'h00, ok}, 8'h01);
  endtask : wr
  task automatic rd(input logic [7:0] ofs, input logic [7:0] e);
    logic ok;
    i_i2c_host_model.reg_read(cur_id, ofs, got, ok);
    chk({7'h00, ok}, 8'h01);
    chk(got, e);
  endtask : rd
  task automatic pulses(input int want_reload, input logic core_chk);
    chk({6'h00, core_chk ? n_core > b_core : 1'b1, n_reload - b_reload == want_reload}, 8'h03);
    b_core = n_core;
    b_reload = n_reload;
  endtask : pulses
  task automatic tally_and_finish;
    if (err_total == 0 && checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : tally_and_finish
  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    d = 8'($urandom(32'h0000_ed41));
    arst_n = 1'b0;
    ce = 1'b1;
    power_down_pin = 1'b0;
    ident_strap = 7'($urandom);
    ms = $urandom % 4;
    mode_strap = codes[ms];
    level_strap = 1'($urandom);
    cur_id = ident_strap;
    idle(3);
    arst_n = 1'b1;
    idle(6);
    chk({7'h00, op_mode_settled}, 8'h00);
    power_down_pin = 1'b1;
    idle(20);
    chk({1'b0, bus_target_ident}, {1'b0, ident_strap});
    chk({5'h00, op_mode}, {5'h00, mode_strap});
    rd(8'h00, {ident_strap, 1'b0});
    rd(8'h01, 8'h00);
    rd(8'h02, cfg_dflt(level_strap));
    rd(8'h03, mode_rd(1'b0, mode_strap));
    nid = ident_strap ^ 7'(1 + $urandom % 127);
    wr(8'h00, {nid, 1'b0});
    rd(8'h00, {ident_strap, 1'b0});
    wr(8'h00, {nid, 1'b1});
    cur_id = nid;
    chk({1'b0, bus_target_ident}, {1'b0, nid});
    rd(8'h00, {nid, 1'b1});
    wr(8'h00, {nid, 1'b0});
    cur_id = ident_strap;
    rd(8'h00, {ident_strap, 1'b0});
    for (int i = 0; i < 6; i++) begin
      d = (i == 0) ? 8'hff : 8'($urandom);
      d[5:4] = lanes[i % 3];
      wr(8'h02, d);
      rd(8'h02, d & 8'h73);
      got = {1'b0, clock_lane_continuous, data_lane_sel, 2'b00, crc_gen_enable, i2c_level_1v8};
      chk(got, d & 8'h73);
    end
    wr(8'h03, {3'b111, 1'b0, 1'b1, ~mode_strap});
    rd(8'h03, mode_rd(1'b0, mode_strap));
    foreach (codes[i]) begin
      wr(8'h03, {3'b000, 1'b1, 1'b0, codes[i]});
      chk({5'h00, op_mode}, {5'h00, codes[i]});
      rd(8'h03, mode_rd(1'b1, codes[i]));
    end
    wr(8'h03, 8'h00);
    rd(8'h03, mode_rd(1'b0, mode_strap));
    b_core = n_core;
    b_reload = n_reload;
    wr(8'h01, 8'h01);
    pulses(0, 1'b1);
    rd(8'h01, 8'h00);
    rd(8'h02, d & 8'h73);
    wr(8'h00, {nid, 1'b1});
    cur_id = nid;
    wr(8'h01, 8'h02);
    cur_id = ident_strap;
    pulses(0, 1'b1);
    rd(8'h00, {ident_strap, 1'b0});
    rd(8'h02, cfg_dflt(level_strap));
    rd(8'h01, 8'h00);
    wr(8'h02, d);
    wr(8'h01, 8'h04);
    pulses(1, 1'b0);
    rd(8'h02, cfg_dflt(level_strap));
    rd(8'h01, 8'h00);
    wr(8'h04, 8'($urandom));
    rd(8'h04, RSVD_RD);
    ce = 1'b0;
    power_down_pin = 1'b0;
    mode_strap = codes[(ms + 1 + $urandom % 3) % 4];
    idle(10);
    chk({7'h00, op_mode_settled}, 8'h01);
    ce = 1'b1;
    idle(10);
    chk({7'h00, op_mode_settled}, 8'h00);
    power_down_pin = 1'b1;
    idle(20);
    chk({5'h00, op_mode}, {5'h00, mode_strap});
    rd(8'h03, mode_rd(1'b0, mode_strap));
    tally_and_finish();
  end
endmodule : serializer_general_config_regs_tb_top
